// >>> core/dmrc_ctrl.sv
// controller end: AXI4-Lite command registers driving the command/address link
`timescale 1ns/1ns
`include "dmrc_map.svh"
module dmrc_ctrl #(
    parameter int unsigned INIT_CYC = `DMRC_INIT_CYC,
    parameter int unsigned MRW_CYC  = `DMRC_MRW_CYC,
    parameter int unsigned READ_LAT = `DMRC_READ_LAT
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // link to the memory die
    dmrc_if.ctl              link
);
    import dmrc_pkg::*;

    if (READ_LAT < 1 || INIT_CYC < 1 || MRW_CYC < 1) begin : g_chk
        $error("dmrc_ctrl: parameter out of range");
    end

    dmrc_ctl_state_t state_reg;
    logic [31:0]     cnt_reg;
    logic [7:0]      aw_addr_reg;
    logic [31:0]     w_data_reg;
    logic [3:0]      w_strb_reg;
    logic [7:0]      ma_reg;
    logic [7:0]      op_reg;
    logic            rd_reg;
    logic            odt_en_reg;
    logic            refused_reg;
    logic            rdone_reg;
    logic [7:0]      rbyte_reg;
    logic [7:0]      pat_reg;
    logic [2:0]      bidx_reg;
    logic            do_write;
    logic            launch;
    logic            is_zq;

    assign do_write = !awready && !wready && !bvalid;
    assign launch   = do_write && aw_addr_reg == `DMRC_OFF_CMD && w_strb_reg[2:0] == 3'h7;
    assign is_zq    = !rd_reg && ma_reg == `DMRC_MA_ZQ;

    // axi write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b1;
            wready      <= 1'b1;
            bvalid      <= 1'b0;
            bresp       <= `DMRC_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            odt_en_reg  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready     <= 1'b0;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready     <= 1'b0;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (do_write) begin
                awready <= 1'b1;
                wready  <= 1'b1;
                bvalid  <= 1'b1;
                bresp   <= `DMRC_RESP_OKAY;
                if (aw_addr_reg == `DMRC_OFF_CTRL && w_strb_reg[0]) begin
                    odt_en_reg <= w_data_reg[`DMRC_CTRL_ODT_BIT];
                end else if (aw_addr_reg > `DMRC_OFF_CTRL || aw_addr_reg[1:0] != 2'h0) begin
                    bresp <= `DMRC_RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `DMRC_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `DMRC_RESP_OKAY;
            unique case (araddr)
                `DMRC_OFF_CMD:   rdata <= {15'h0, rd_reg, ma_reg, op_reg};
                `DMRC_OFF_STAT:  rdata <= {29'h0, rdone_reg, refused_reg, state_reg != CS_IDLE};
                `DMRC_OFF_RDATA: rdata <= {24'h0, rbyte_reg};
                `DMRC_OFF_PAT:   rdata <= {24'h0, pat_reg};
                `DMRC_OFF_CTRL:  rdata <= {31'h0, odt_en_reg};
                default: begin
                    rdata <= 32'h0;
                    rresp <= `DMRC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // command sequence: optional termination drop, stable bus, strobe, stable bus, wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= CS_IDLE;
            cnt_reg     <= 32'h0;
            ma_reg      <= 8'h00;
            op_reg      <= 8'h00;
            rd_reg      <= 1'b0;
            refused_reg <= 1'b0;
            link.cs_n   <= 1'b1;
            link.cke    <= 1'b1;
            link.ca_rise <= 10'h000;
            link.ca_fall <= 10'h000;
            link.termination_control <= 1'b0;
        end else begin
            link.cke <= 1'b1;                                                 // [R20]
            link.termination_control <= odt_en_reg && !(is_zq && state_reg != CS_IDLE);
            unique case (state_reg)
                CS_IDLE: begin
                    if (launch) begin
                        rd_reg    <= w_data_reg[`DMRC_CMD_RD_BIT];
                        ma_reg    <= w_data_reg[`DMRC_CMD_MA_LSB +: 8];
                        op_reg    <= w_data_reg[`DMRC_CMD_OP_LSB +: 8];
                        state_reg <= CS_ODT_OFF;
                    end
                end
                CS_ODT_OFF: begin
                    // termination goes low at the end of this cycle, two cycles before any calibration strobe
                    if (!rd_reg && ma_reg == `DMRC_MA_RESET) begin
                        op_reg <= `DMRC_OP_RESET_SAFE;                        // [R13]
                    end
                    state_reg <= CS_PRE;                                      // [R16] [R17]
                end
                CS_PRE: begin
                    link.ca_rise <= {ma_reg[5:0], rd_reg ? `DMRC_CA_READ : `DMRC_CA_WRITE};
                    link.ca_fall <= {op_reg, ma_reg[7:6]};                    // [R07] [R23]
                    state_reg    <= CS_ISSUE;                                 // [R14]
                end
                CS_ISSUE: begin
                    link.cs_n <= 1'b0;
                    state_reg <= CS_POST;
                    if (rd_reg) begin
                        cnt_reg <= 32'(READ_LAT + `DMRC_BURST + 1);
                    end else if (ma_reg == `DMRC_MA_RESET) begin
                        cnt_reg <= INIT_CYC + 1;                              // [R12]
                    end else if (is_zq && dmrc_zq_cycles(op_reg) != 32'h0) begin
                        cnt_reg <= dmrc_zq_cycles(op_reg) + 32'h1;            // [R18] [R21]
                    end else begin
                        cnt_reg <= MRW_CYC + 1;                               // [R09]
                    end
                end
                CS_POST: begin
                    link.cs_n <= 1'b1;                                        // [R14]
                    cnt_reg   <= cnt_reg - 32'h1;
                    state_reg <= CS_WAIT;
                end
                CS_WAIT: begin
                    // only no-ops go out while waiting
                    if (cnt_reg <= 32'h1) begin
                        state_reg <= CS_IDLE;                                 // [R19]
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
            endcase
            if (launch && state_reg != CS_IDLE) begin
                refused_reg <= 1'b1;
            end else if (launch) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // capture of a read burst; rdone stays until the next command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bidx_reg  <= 3'h0;
            rbyte_reg <= 8'h00;
            pat_reg   <= 8'h00;
            rdone_reg <= 1'b0;
        end else if (state_reg == CS_ISSUE) begin
            bidx_reg  <= 3'h0;
            rdone_reg <= 1'b0;
        end else if (!link.dq_oe_n && rd_reg) begin
            if (bidx_reg == 3'h0) begin
                rbyte_reg <= link.dq[7:0];
            end
            pat_reg[bidx_reg] <= link.dq[0];                                  // [R05]
            bidx_reg          <= bidx_reg + 3'h1;
            rdone_reg         <= bidx_reg == 3'h7;
        end
    end
endmodule : dmrc_ctrl

// >>> core/dmrc_device.sv
// memory die end: mode register write/read decode, reset, impedance calibration, temperature
//
// Functional notes
// [R01] temperature status refreshed at least every interval
// [R02] status fresh on low-power exit
// [R03] update threshold keeps 2 degree margin
// [R04] controller polls fast enough for gradient; dmrc_ctrl never polls, temperature is read only by a commanded read
// [R05] pattern registers return pattern on lane bit 0
// [R06] other lane bits replicate bit 0
// [R07] write decode: cs low, ca 3:0 low
// [R08] writes to read-only registers ignored
// [R09] controller sends only no-ops during write period
// [R10] writes only with all banks idle
// [R11] reset write restores defaults, auto-initialises
// [R12] controller uses boot timing after reset write
// [R13] reset write may use transition-free operand
// [R14] ca bus held stable around reset write
// [R15] four calibration kinds, each own duration
// [R16] calibration only idle, termination already off
// [R17] termination off before calibration command
// [R18] data bus quiet, unterminated while calibrating
// [R19] no quiet time after impedance reset
// [R20] clock enable high, no-ops during calibration
// [R21] shared resistor calibrations never overlap
// [R22] calibration circuitry powered down when done
// [R23] read decode: ca 2:0 low, ca3 high
// [R24] selector addresses and operands from register map
`timescale 1ns/1ns
`include "dmrc_map.svh"
module dmrc_device #(
    parameter int unsigned TSI_CYC  = `DMRC_TSI_CYC,
    parameter int unsigned INIT_CYC = `DMRC_INIT_CYC,
    parameter int unsigned MRW_CYC  = `DMRC_MRW_CYC,
    parameter int unsigned READ_LAT = `DMRC_READ_LAT,
    parameter logic [7:0]  PAT_A    = `DMRC_PAT_A,
    parameter logic [7:0]  PAT_B    = `DMRC_PAT_B
) (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // link to the controller
    dmrc_if.dev                           link,
    // array and sensor side
    input  wire logic                     banks_active,
    input  wire logic signed [7:0]        die_temp_c,
    input  wire logic                     lp_exit,
    // status
    output dmrc_pkg::dmrc_temp_code_t     temp_status,
    output logic                          cfg_busy,
    output logic                          auto_init,
    output logic                          zq_cal_on
);
    import dmrc_pkg::*;

    if (READ_LAT < 1 || READ_LAT > 200 || TSI_CYC < 2 || INIT_CYC < 1 || MRW_CYC < 1) begin : g_chk
        $error("dmrc_device: parameter out of range");
    end

    localparam logic [7:0] LAST_T = 8'(READ_LAT + `DMRC_BURST - 1);

    dmrc_dev_state_t state_reg;
    logic [31:0]     cnt_reg;
    logic [31:0]     tsi_reg;
    logic [7:0]      mr_reg [0:255];
    logic            rd_on_reg;
    logic [7:0]      rd_t_reg;
    logic [7:0]      rd_ma_reg;
    logic [7:0]      rd_val_reg;

    logic [7:0]      ma;
    logic [7:0]      op;
    logic            cmd_write;
    logic            cmd_read;
    logic            wr_ok;
    logic            is_reset;
    logic [31:0]     zq_cyc;
    logic [7:0]      beat;

    function automatic logic read_only(input logic [7:0] a);
        return a == `DMRC_MA_TEMP || a == `DMRC_MA_PAT_A || a == `DMRC_MA_PAT_B;
    endfunction : read_only

    // reading raised by the margin so the controller acts before the real limit
    function automatic dmrc_temp_code_t temp_code(input logic signed [7:0] t);
        logic signed [9:0] adj;
        adj = 10'(t) + 10'sd`DMRC_TEMP_MARGIN_C;
        if (adj > 10'sd`DMRC_TEMP_MAX_C) begin
            return `DMRC_TCODE_MAX;
        end else if (adj > 10'sd`DMRC_TEMP_HOT_C) begin
            return `DMRC_TCODE_HOT;
        end
        return `DMRC_TCODE_NORMAL;
    endfunction : temp_code

    // one beat per clock; lane bits above bit 0 copy it for the pattern registers
    function automatic logic [15:0] beat_word(input logic [7:0] a, input logic [2:0] b,
                                              input logic [7:0] v);
        logic p;
        p = (a == `DMRC_MA_PAT_A) ? PAT_A[b] : PAT_B[b];
        if (a == `DMRC_MA_PAT_A || a == `DMRC_MA_PAT_B) begin
            return {{8{p}}, {8{p}}};                                  // [R05] [R06]
        end
        return (b == 3'h0) ? {8'h00, v} : 16'h0000;
    endfunction : beat_word

    assign ma        = {link.ca_fall[1:0], link.ca_rise[9:4]};
    assign op        = link.ca_fall[9:2];
    assign cmd_write = !link.cs_n && link.ca_rise[3:0] == `DMRC_CA_WRITE;       // [R07]
    assign cmd_read  = !link.cs_n && link.ca_rise[3:0] == `DMRC_CA_READ;        // [R23]
    // anything but idle with all banks precharged drops the write
    assign wr_ok     = cmd_write && state_reg == DS_IDLE && !banks_active;      // [R10]
    assign is_reset  = ma == `DMRC_MA_RESET;                                    // [R24]
    assign zq_cyc    = (ma == `DMRC_MA_ZQ) ? dmrc_zq_cycles(op) : 32'h0;        // [R15] [R24]
    assign beat      = rd_t_reg - 8'(READ_LAT - 1);

    // command sequencing and its period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= DS_IDLE;
            cnt_reg   <= 32'h0;
            cfg_busy  <= 1'b0;
            auto_init <= 1'b0;
            zq_cal_on <= 1'b0;
        end else begin
            unique case (state_reg)
                DS_IDLE: begin
                    if (wr_ok && is_reset) begin
                        state_reg <= DS_AUTO_INIT;                            // [R11]
                        cnt_reg   <= INIT_CYC - 1;
                        cfg_busy  <= 1'b1;
                        auto_init <= 1'b1;
                    end else if (wr_ok && zq_cyc != 32'h0) begin
                        state_reg <= DS_ZQ;                                   // [R15]
                        cnt_reg   <= zq_cyc - 32'h1;
                        cfg_busy  <= 1'b1;
                        zq_cal_on <= 1'b1;
                    end else if (wr_ok) begin
                        state_reg <= DS_MRW_WAIT;
                        cnt_reg   <= MRW_CYC - 1;
                        cfg_busy  <= 1'b1;
                    end
                end
                DS_MRW_WAIT, DS_AUTO_INIT, DS_ZQ: begin
                    if (cnt_reg == 32'h0) begin
                        state_reg <= DS_IDLE;                                 // [R11]
                        cfg_busy  <= 1'b0;
                        auto_init <= 1'b0;
                        zq_cal_on <= 1'b0;                                    // [R22]
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
            endcase
        end
    end

    // mode register storage
    always_ff @(posedge aclk) begin
        if (!aresetn || (wr_ok && is_reset)) begin
            for (int i = 0; i < 256; i++) begin
                mr_reg[i] <= `DMRC_MR_RESET_VAL;                              // [R11]
            end
        end else if (wr_ok && !read_only(ma)) begin                           // [R08]
            mr_reg[ma] <= op;
        end
    end

    // temperature sampling; a low-power exit forces a fresh sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tsi_reg     <= 32'h0;
            temp_status <= `DMRC_TCODE_NORMAL;
        end else if (tsi_reg == 32'h0 || lp_exit) begin
            tsi_reg     <= TSI_CYC - 1;                                       // [R01] [R02]
            temp_status <= temp_code(die_temp_c);                             // [R03]
        end else begin
            tsi_reg <= tsi_reg - 32'h1;
        end
    end

    // read burst timing; reads are served in idle even with banks open
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_on_reg  <= 1'b0;
            rd_t_reg   <= 8'h00;
            rd_ma_reg  <= 8'h00;
            rd_val_reg <= 8'h00;
        end else if (!rd_on_reg && cmd_read && state_reg == DS_IDLE) begin
            rd_on_reg  <= 1'b1;                                               // [R23]
            rd_t_reg   <= 8'h00;
            rd_ma_reg  <= ma;
            rd_val_reg <= (ma == `DMRC_MA_TEMP) ? {5'h00, temp_status} : mr_reg[ma];
        end else if (rd_on_reg) begin
            rd_t_reg <= rd_t_reg + 8'h01;
            if (rd_t_reg == LAST_T) begin
                rd_on_reg <= 1'b0;
            end
        end
    end

    // data pins; idle is released, so calibration windows see a quiet bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.dq      <= 16'h0000;
            link.dq_oe_n <= 1'b1;
            link.dqs     <= 1'b0;
        end else if (rd_on_reg && rd_t_reg >= 8'(READ_LAT - 1) && rd_t_reg < LAST_T) begin
            link.dq      <= beat_word(rd_ma_reg, beat[2:0], rd_val_reg);      // [R23]
            link.dq_oe_n <= 1'b0;
            link.dqs     <= ~link.dqs;
        end else begin
            link.dq      <= 16'h0000;                                         // [R18]
            link.dq_oe_n <= 1'b1;
            link.dqs     <= 1'b0;
        end
    end
endmodule : dmrc_device

// >>> core/dmrc_if.sv
// command/address link between controller and memory die
`timescale 1ns/1ns
interface dmrc_if;
    logic        cs_n;
    logic        cke;
    logic        termination_control;
    logic [9:0]  ca_rise;
    logic [9:0]  ca_fall;
    logic [15:0] dq;
    logic        dq_oe_n;
    logic        dqs;
    modport dev (input cs_n, cke, termination_control, ca_rise, ca_fall,
                 output dq, dq_oe_n, dqs);
    modport ctl (output cs_n, cke, termination_control, ca_rise, ca_fall,
                 input dq, dq_oe_n, dqs);
endinterface : dmrc_if

// >>> core/dmrc_map.svh
// offsets, field positions, reset values and timing counts of the mode register command unit
`ifndef DMRC_MAP_SVH
`define DMRC_MAP_SVH
`define DMRC_CLK_NS          40
`define DMRC_CYC_CEIL(ns)    (((ns) + `DMRC_CLK_NS - 1) / `DMRC_CLK_NS)
`define DMRC_T_INITIAL_IMPEDANCE_CAL_NS     1000
`define DMRC_T_ZQLONG_NS     360
`define DMRC_T_ZQSHORT_NS    90
`define DMRC_T_IMPEDANCE_DEFAULT_RESET_NS    50
`define DMRC_T_INIT_NS       1000
`define DMRC_T_TSI_MS        32
`define DMRC_INITIAL_IMPEDANCE_CAL_CYC      `DMRC_CYC_CEIL(`DMRC_T_INITIAL_IMPEDANCE_CAL_NS)
`define DMRC_ZQLONG_CYC      `DMRC_CYC_CEIL(`DMRC_T_ZQLONG_NS)
`define DMRC_ZQSHORT_CYC     `DMRC_CYC_CEIL(`DMRC_T_ZQSHORT_NS)
`define DMRC_IMPEDANCE_DEFAULT_RESET_CYC     `DMRC_CYC_CEIL(`DMRC_T_IMPEDANCE_DEFAULT_RESET_NS)
`define DMRC_INIT_CYC        `DMRC_CYC_CEIL(`DMRC_T_INIT_NS)
`define DMRC_TSI_CYC         ((`DMRC_T_TSI_MS * 1000000) / `DMRC_CLK_NS)
`define DMRC_MRW_CYC         10
`define DMRC_READ_LAT        6
`define DMRC_BURST           8
`define DMRC_MA_TEMP         8'h04
`define DMRC_MA_ZQ           8'h0A
`define DMRC_MA_PAT_A        8'h20
`define DMRC_MA_PAT_B        8'h28
`define DMRC_MA_RESET        8'h3F
`define DMRC_OP_ZQ_INIT      8'hFF
`define DMRC_OP_ZQ_LONG      8'hAB
`define DMRC_OP_ZQ_SHORT     8'h56
`define DMRC_OP_ZQ_RESET     8'hC3
`define DMRC_OP_RESET_SAFE   8'hFC
`define DMRC_PAT_A           8'h55
`define DMRC_PAT_B           8'h33
`define DMRC_MR_RESET_VAL    8'h00
`define DMRC_CA_WRITE        4'h0
`define DMRC_CA_READ         4'h8
`define DMRC_TEMP_MARGIN_C   2
`define DMRC_TEMP_HOT_C      85
`define DMRC_TEMP_MAX_C      105
`define DMRC_TCODE_NORMAL    3'h3
`define DMRC_TCODE_HOT       3'h5
`define DMRC_TCODE_MAX       3'h7
`define DMRC_OFF_CMD         8'h00
`define DMRC_OFF_STAT        8'h04
`define DMRC_OFF_RDATA       8'h08
`define DMRC_OFF_PAT         8'h0C
`define DMRC_OFF_CTRL        8'h10
`define DMRC_CMD_OP_LSB      0
`define DMRC_CMD_MA_LSB      8
`define DMRC_CMD_RD_BIT      16
`define DMRC_STAT_BUSY_BIT   0
`define DMRC_STAT_REFUSE_BIT 1
`define DMRC_STAT_RDONE_BIT  2
`define DMRC_CTRL_ODT_BIT    0
`define DMRC_RESP_OKAY       2'h0
`define DMRC_RESP_SLVERR     2'h2
`endif

// >>> core/dmrc_pkg.sv
// types and shared helpers of the mode register command unit
`include "dmrc_map.svh"
package dmrc_pkg;
    typedef enum logic [1:0] {DS_IDLE, DS_MRW_WAIT, DS_AUTO_INIT, DS_ZQ} dmrc_dev_state_t;
    typedef enum logic [2:0] {CS_IDLE, CS_ODT_OFF, CS_PRE, CS_ISSUE, CS_POST, CS_WAIT}
        dmrc_ctl_state_t;
    typedef logic [2:0] dmrc_temp_code_t;
    typedef logic [7:0] dmrc_byte_t;

    // zero for an operand that starts no calibration
    function automatic logic [31:0] dmrc_zq_cycles(input dmrc_byte_t op);
        logic [31:0] c;
        c = 32'h0;
        unique case (op)
            `DMRC_OP_ZQ_INIT:  c = 32'(`DMRC_INITIAL_IMPEDANCE_CAL_CYC);
            `DMRC_OP_ZQ_LONG:  c = 32'(`DMRC_ZQLONG_CYC);
            `DMRC_OP_ZQ_SHORT: c = 32'(`DMRC_ZQSHORT_CYC);
            `DMRC_OP_ZQ_RESET: c = 32'(`DMRC_IMPEDANCE_DEFAULT_RESET_CYC);
            default:           c = 32'h0;
        endcase
        return c;
    endfunction : dmrc_zq_cycles
endpackage : dmrc_pkg

// >>> testbench/dmrc_monitor.sv
// link checker for the mode register command unit
`timescale 1ns/1ns
module dmrc_monitor (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // link
    input wire logic       cs_n,
    input wire logic       cke,
    input wire logic       termination_control,
    input wire logic [9:0] ca_rise,
    input wire logic [9:0] ca_fall,
    input wire logic       dq_oe_n,
    input wire logic       dqs
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [7:0] num = {ca_fall[1:0], ca_rise[9:4]};
    wire logic       wr  = !cs_n && ca_rise[3:0] == 4'h0;
    wire logic       zq  = wr && num == 8'h0A && ca_fall[9:2] inside {8'hFF, 8'hAB, 8'h56, 8'hC3};
    a_cke_held: assert property (cke) else $error("cke low");
    a_cs_single: assert property (!cs_n |=> cs_n) else $error("cs_n held");
    a_ca_steady: assert property (!cs_n |-> $stable(ca_rise) && $stable(ca_fall)
        ##1 $stable(ca_rise) && $stable(ca_fall)) else $error("ca moved");
    a_reset_op: assert property (wr && num == 8'h3F |-> ca_fall[9:2] == 8'hFC && ca_fall == ca_rise)
        else $error("reset operand");
    a_zq_unterm: assert property (zq |-> !termination_control) else $error("term on");
    a_zq_quiet: assert property (zq |=> (cs_n && dq_oe_n)[*3]) else $error("zq busy");
    a_read_start: assert property (!cs_n && ca_rise[3:0] == 4'h8 |-> ##[1:8] $fell(dq_oe_n))
        else $error("no read burst");
    a_burst_len: assert property ($fell(dq_oe_n) |-> !dq_oe_n[*8] ##1 dq_oe_n)
        else $error("burst length");
    a_dqs_beat: assert property (!dq_oe_n && !$fell(dq_oe_n) |-> dqs != $past(dqs))
        else $error("dqs still");
    c_reset: cover property (wr && num == 8'h3F);
    c_zq: cover property (zq);
    c_burst: cover property ($fell(dq_oe_n));
endmodule : dmrc_monitor

// >>> testbench/tb.sv
// self-checking bench: controller and memory die joined over the link
`timescale 1ns/1ns
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, banks_active, lp_exit;
    logic awready, wready, bvalid, arready, rvalid, cfg_busy, auto_init, zq_cal_on;
    logic        [7:0]  awaddr, araddr;
    logic signed [7:0]  die_temp_c;
    logic        [31:0] wdata, rdata, rd;
    logic        [1:0]  bresp, rresp, rs;
    logic        [2:0]  temp_status;
    logic        [7:0]  zop[4] = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
    int ns[4] = '{1000, 360, 90, 50};
    int n_mismatch, total_checks, zq_len, ai_len, mr[256], i, t;
    dmrc_if link();
    dmrc_ctrl dmrc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link(link));
    dmrc_device #(.TSI_CYC(50)) dmrc_device_i (.aclk(aclk), .aresetn(aresetn), .link(link),
        .banks_active(banks_active), .die_temp_c(die_temp_c), .lp_exit(lp_exit),
        .temp_status(temp_status), .cfg_busy(cfg_busy), .auto_init(auto_init),
        .zq_cal_on(zq_cal_on));
    dmrc_monitor dmrc_monitor_i (.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n),
        .cke(link.cke), .termination_control(link.termination_control),
        .ca_rise(link.ca_rise), .ca_fall(link.ca_fall), .dq_oe_n(link.dq_oe_n), .dqs(link.dqs));
    initial begin aclk = 1'b0; forever #20 aclk = ~aclk; end
    // run lengths of the busy flags, sampled at each rising edge
    always @(posedge aclk) begin zq_len += zq_cal_on; ai_len += auto_init + cfg_busy; end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
    endtask : axr
    // polls busy; the watchdog cuts a hang
    task automatic cmd(input logic [16:0] v);
        axw(8'h00, {15'h0, v});
        rd = 32'h1;
        while (rd[0]) axr(8'h04);
    endtask : cmd
    task automatic rdchk(input int n, input int e);
        cmd({1'b1, n[7:0], 8'h00});
        axr(8'h08);
        chk("register", e, rd);
    endtask : rdchk
    task automatic complete_run;
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial begin #(40 * 40000); n_mismatch++; complete_run; end
    initial begin
        {awvalid, wvalid, arvalid, banks_active, lp_exit} = '0;
        {bready, rready} = 2'h3;
        awaddr = '0; araddr = '0; wdata = '0; die_temp_c = 8'sh14; aresetn = 1'b0;
        t = $urandom(38294);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(8'h14); chk("unmapped", 2, rs);
        axw(8'h10, 1); axr(8'h10); chk("ctrl", 1, rd);
        for (i = 0; i < 4; i++) begin
            t = $urandom_range(8'hFF, 8'h40);
            mr[t] = $urandom_range(8'hFF, 0);
            cmd({1'b0, t[7:0], mr[t][7:0]});
            rdchk(t, mr[t]);
        end
        banks_active <= 1'b1;
        cmd({1'b0, t[7:0], ~mr[t][7:0]});
        banks_active <= 1'b0;
        rdchk(t, mr[t]);
        for (i = 0; i < 2; i++) begin
            cmd({1'b0, i ? 8'h28 : 8'h20, 8'h00});
            rdchk(i ? 8'h28 : 8'h20, 8'hFF);
            axr(8'h0C); chk("pattern", i ? 8'h33 : 8'h55, rd);
        end
        for (i = 0; i < 4; i++) begin
            zq_len = 0;
            cmd({9'h00A, zop[i]});
            chk("zq cycles", (ns[i] + 39) / 40, zq_len);
            chk("zq power", 0, zq_cal_on);
        end
        ai_len = 0;
        cmd({9'h03F, 8'h00});
        chk("auto init", 50, ai_len);
        rdchk(t, 0);
        for (i = 0; i < 3; i++) begin
            die_temp_c <= 8'($urandom_range(10, 0) + (i == 0 ? 20 : (i == 1 ? 90 : 108)));
            if (i == 1) begin
                lp_exit <= 1'b1;
                @(posedge aclk);
                lp_exit <= 1'b0;
                repeat (3) @(posedge aclk);
            end else repeat (55) @(posedge aclk);
            chk("temp status", 3 + 2 * i, temp_status);
            rdchk(8'h04, 3 + 2 * i);
        end
        complete_run;
    end
endmodule : tb
